/* File: hdl/xcvr_cfg.svh */
`ifndef XCVR_CFG_SVH
`define XCVR_CFG_SVH
// command type field and register address field
`define CMD_TYPE_MSB      7
`define CMD_TYPE_LSB      5
`define CMD_ADDR_MSB      4
`define CMD_ADDR_LSB      0
// register addresses
`define REG_OPMODE        5'h01
`define REG_SLEEP         5'h04
`define REG_LIM_MIN       5'h05
`define REG_LIM_MAX       5'h06
`define REG_CHECK_BITS    5'h07
`define REG_STATUS        5'h08
// fields of the operating register
`define OP_LO_BIT         0
`define OP_HI_BIT         1
`define SUPPLY_ON_BIT     2
`define TRANSPARENT_BIT   3
// fields of the sleep register
`define SLEEP_MSB         4
`define STRETCH_BIT       5
// fields of the status register
`define ST_WAKE_BIT       5
`define ST_LOW_BIT        6
`define ST_AUX_BIT        7
// reset values
`define CTRL_RST          8'h00
`define LIM_MIN_RST       8'h0E
`define LIM_MAX_RST       8'h18
// synchroniser reset: key pins idle high, everything else low
`define SYNC_RST          13'h007C
// timing counts; sleep unit and settle ticks in digital clock periods, divider in system clock periods
`define SLEEP_UNIT        1024
`define STRETCH_FACTOR    8
`define EDGES_PER_STEP    6
`define SETTLE_TICKS      16
`define DCLK_DIV          8
`endif

/* File: hdl/xcvr_ctrl.sv */
// Behaviour
// - command byte then data bytes, msb first
// - buffer count shifted out under command
// - serial logic reset while select low
// - read buffer streams buffered bytes
// - write buffer stores bytes, echoes them
// - register read returns one or more
// - register write accepts bytes, echoes them
// - off only with supply off, pins idle
// - delete command drops interrupt pin
// - bits 7..5 type, 4..0 address
// - low bits ignored for other commands
// - command codes decoded per table
// - no serial traffic while reset low
// - select low, not transparent: output released
// - select low, transparent: demod on output
// - mode field picks polling or continuous
// - polling loops sleep, start-up, check
// - awake pin shows polling condition
// - sleep is field times 1024 periods
// - stretch bit multiplies sleep by 8
// - pll lock, then settling, then check
// - edge intervals checked against window
// - status read clears flags and interrupt
// - status register at address 8
`timescale 1ns/10ps
`include "xcvr_cfg.svh"

module xcvr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic                       sys_clk_i,
	input  wire logic                       rst_n_i,
	input  wire logic                       in_valid_i,
	output logic                            in_ready_o,
	input  wire logic [WIDTH-1:0]           in_data_i,
	output logic                            out_valid_o,
	input  wire logic                       out_ready_i,
	output logic      [WIDTH-1:0]           out_data_o,
	output logic      [$clog2(DEPTH+1)-1:0] count_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0]           mem [DEPTH];   // storage flops
	logic [AW-1:0]              wr_ptr;        // next write slot
	logic [AW-1:0]              rd_ptr;        // oldest entry
	logic [$clog2(DEPTH+1)-1:0] fill;          // entries held
	logic                       push;
	logic                       pop;

	assign in_ready_o  = (fill != DEPTH[$clog2(DEPTH+1)-1:0]);
	assign out_valid_o = (fill != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_ready_i && out_valid_o;
	assign out_data_o  = mem[rd_ptr];
	assign count_o     = fill;

	// write side
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// pointers and fill level
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill   <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			fill <= fill + {{($clog2(DEPTH+1)-1){1'b0}}, push}
				- {{($clog2(DEPTH+1)-1){1'b0}}, pop};
		end
	end
endmodule

module xcvr_ctrl #(
	parameter int DCLK_DIV  = `DCLK_DIV,
	parameter int BUF_DEPTH = 8
) (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       reset_out_n_i,       // device reset pin level
	input  wire logic       cs_i,                // serial select, active high
	input  wire logic       sck_i,               // serial clock from host
	input  wire logic       serial_in_line_i,
	output logic            serial_out_line_o,
	output logic            serial_out_line_oe_o,
	input  wire logic       analog_dummy_i,      // unused spare, kept low
	input  wire logic       power_wake_pin_i,
	input  wire logic       supply_low_i,        // supply comparator output
	input  wire logic       aux_power_i,         // auxiliary supply good
	input  wire logic [4:0] key_inputs_i,        // keys, pressed when low
	input  wire logic       demod_i,             // demodulated data
	input  wire logic       pll_lock_i,
	output logic            interrupt_pin_o,
	output logic            off_mode_o,
	output logic            receiver_awake_pin_o,
	output logic            pll_en_o,
	output logic            sig_proc_en_o,
	output logic            receiving_o
);
	import xcvr_pkg::*;
	localparam int NSYNC = 13;
	localparam int CW    = $clog2(BUF_DEPTH + 1);

	// two-stage synchroniser for every pin input but the device reset pin and the unused spare
	logic [NSYNC-1:0] sync1;
	logic [NSYNC-1:0] sync2;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1 <= `SYNC_RST;   // keys idle, no false key edge
			sync2 <= `SYNC_RST;
		end else begin
			sync1 <= {cs_i, sck_i, serial_in_line_i, power_wake_pin_i, supply_low_i,
				aux_power_i, key_inputs_i, demod_i, pll_lock_i};
			sync2 <= sync1;
		end
	end

	ser_pins_t  pins;                  // synchronised serial pins
	logic       wake_s;
	logic       low_s;
	logic       aux_s;
	logic [4:0] key_s;
	logic       demod_s;
	logic       lock_s;
	assign {pins, wake_s, low_s, aux_s, key_s, demod_s, lock_s} = sync2;

	logic sck_d;       // previous sck sample
	logic demod_d;     // previous demod sample
	logic wake_d;
	logic aux_d;
	logic [4:0] key_d;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sck_d   <= 1'b0;
			demod_d <= 1'b0;
			wake_d  <= 1'b0;
			aux_d   <= 1'b0;
			key_d   <= 5'h1F;
		end else begin
			sck_d   <= pins.sck;
			demod_d <= demod_s;
			wake_d  <= wake_s;
			aux_d   <= aux_s;
			key_d   <= key_s;
		end
	end

	// serial port held in reset when deselected or device reset low
	logic ser_rst;
	logic sck_rise;
	logic sck_fall;
	assign ser_rst  = !pins.cs || !reset_out_n_i;
	assign sck_rise = !ser_rst && pins.sck && !sck_d;
	assign sck_fall = !ser_rst && !pins.sck && sck_d;

	// shared data buffer
	logic          fifo_in_valid;
	logic          fifo_in_ready;
	logic [7:0]    fifo_in_data;
	logic          fifo_out_valid;
	logic          fifo_pop;
	logic [7:0]    fifo_out_data;
	logic [CW-1:0] fifo_count;
	xcvr_fifo #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_buf (
		.sys_clk_i   (sys_clk_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (fifo_in_valid),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (fifo_in_data),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_out_data),
		.count_o     (fifo_count)
	);

	// serial engine state
	ser_state_t ser_state;
	logic [2:0] bit_cnt;        // bits of current byte
	logic [6:0] rx_sh;          // incoming bits
	logic [7:0] tx_sh;          // outgoing byte, msb on the line
	logic [7:0] tx_next;        // byte for the next frame slot
	logic       tx_load;        // load on the next falling edge
	logic [4:0] reg_addr;       // running register address
	logic       was_rst;        // previous cycle in reset
	logic [7:0] rx_byte;
	logic       byte_done;
	logic [7:0] ctrl [32];      // control registers
	logic [7:0] status;
	logic [7:0] rd_data;
	logic       status_rd;      // status register read this cycle
	logic       del_irq;        // delete interrupt command
	logic       ser_push;       // byte from host into buffer
	logic       rx_push;        // byte from receiver into buffer
	logic [7:0] rx_word;
	cmd_type_t  cmd;
	logic       wake_flag;      // wake pin rose
	logic       low_flag;       // supply seen low
	logic       aux_flag;       // aux supply came up
	logic       rx_event;       // bit check passed
	logic       rx_full;        // assembled byte waiting

	assign rx_byte   = {rx_sh, pins.sdi};
	assign byte_done = sck_rise && (bit_cnt == 3'h7);
	assign cmd       = cmd_type_t'(rx_byte[`CMD_TYPE_MSB:`CMD_TYPE_LSB]);
	assign status    = {aux_flag, low_flag, wake_flag, ~key_s};

	// register read port, status at its fixed address
	logic [4:0] rd_addr;
	assign rd_addr   = (ser_state == S_CMD) ? rx_byte[`CMD_ADDR_MSB:`CMD_ADDR_LSB] : reg_addr;
	assign rd_data   = (rd_addr == `REG_STATUS) ? status : ctrl[rd_addr];
	assign status_rd = byte_done && (rd_addr == `REG_STATUS)
		&& ((ser_state == S_CMD && cmd == CMD_RD_REG) || ser_state == S_RD_REG);
	assign del_irq   = byte_done && ser_state == S_CMD && cmd == CMD_DEL_IRQ;

	// buffer pushes: host writes first, receiver waits
	assign ser_push      = byte_done && ser_state == S_WR_BUF;
	assign fifo_in_valid = ser_push || rx_push;
	assign fifo_in_data  = ser_push ? rx_byte : rx_word;
	assign fifo_pop      = byte_done && fifo_out_valid
		&& ((ser_state == S_CMD && cmd == CMD_RD_BUF) || ser_state == S_RD_BUF);

	// bit counter and input shifter
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_cnt <= '0;
			rx_sh   <= '0;
		end else if (ser_rst) begin
			bit_cnt <= '0;
		end else if (sck_rise) begin
			bit_cnt <= bit_cnt + 3'h1;
			rx_sh   <= rx_byte[6:0];
		end
	end

	// frame phase, address and next reply byte
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ser_state <= S_CMD;
			reg_addr  <= '0;
			tx_next   <= '0;
			tx_load   <= 1'b0;
		end else if (ser_rst) begin
			ser_state <= S_CMD;
			tx_load   <= 1'b0;
		end else if (byte_done) begin
			tx_load <= 1'b1;
			unique case (ser_state)
				S_CMD: begin
					reg_addr <= rx_byte[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
					unique case (cmd)
						CMD_RD_BUF: begin
							ser_state <= S_RD_BUF;
							tx_next   <= fifo_out_valid ? fifo_out_data : 8'h00;
						end
						CMD_WR_BUF: begin
							ser_state <= S_WR_BUF;
							tx_next   <= rx_byte;
						end
						CMD_RD_REG: begin
							ser_state <= S_RD_REG;
							tx_next   <= rd_data;
							reg_addr  <= rx_byte[`CMD_ADDR_MSB:`CMD_ADDR_LSB] + 5'h01;
						end
						CMD_WR_REG: begin
							ser_state <= S_WR_REG;
							tx_next   <= rx_byte;
						end
						default: begin
							ser_state <= S_IGNORE;
							tx_next   <= 8'h00;
						end
					endcase
				end
				S_RD_BUF: begin
					tx_next <= fifo_out_valid ? fifo_out_data : 8'h00;
				end
				S_WR_BUF: begin
					tx_next <= rx_byte;
				end
				S_RD_REG: begin
					tx_next  <= rd_data;
					reg_addr <= reg_addr + 5'h01;
				end
				S_WR_REG: begin
					tx_next  <= rx_byte;
					reg_addr <= reg_addr + 5'h01;
				end
				S_IGNORE: begin
					tx_next <= 8'h00;
				end
			endcase
		end else if (sck_fall) begin
			tx_load <= 1'b0;
		end
	end

	// output shifter: buffer count first, then replies
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_sh   <= '0;
			was_rst <= 1'b1;
		end else begin
			was_rst <= ser_rst;
			if (ser_rst) begin
				tx_sh <= '0;
			end else if (was_rst) begin
				tx_sh <= 8'(fifo_count);
			end else if (sck_fall) begin
				tx_sh <= tx_load ? tx_next : {tx_sh[6:0], 1'b0};
			end
		end
	end

	// control registers written by the host
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 32; i++) begin
				ctrl[i] <= `CTRL_RST;
			end
			ctrl[`REG_LIM_MIN] <= `LIM_MIN_RST;
			ctrl[`REG_LIM_MAX] <= `LIM_MAX_RST;
		end else if (byte_done && ser_state == S_WR_REG && reg_addr != `REG_STATUS) begin
			ctrl[reg_addr] <= rx_byte;
		end
	end

	// status flags, a new event wins over a clearing read
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wake_flag       <= 1'b0;
			low_flag        <= 1'b0;
			aux_flag        <= 1'b0;
			interrupt_pin_o <= 1'b0;
		end else begin
			if (wake_s && !wake_d) begin
				wake_flag <= 1'b1;
			end else if (status_rd) begin
				wake_flag <= 1'b0;
			end
			if (low_s) begin
				low_flag <= 1'b1;
			end else if (status_rd) begin
				low_flag <= 1'b0;
			end
			if (aux_s && !aux_d) begin
				aux_flag <= 1'b1;
			end else if (status_rd) begin
				aux_flag <= 1'b0;
			end
			if ((wake_s && !wake_d && !wake_flag) || (aux_s && !aux_d && !aux_flag)
				|| (key_s != key_d) || rx_event) begin
				interrupt_pin_o <= 1'b1;
			end else if (status_rd || del_irq) begin
				interrupt_pin_o <= 1'b0;
			end
		end
	end

	// off mode entry guarded by supply and pin levels
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			off_mode_o <= 1'b0;
		end else if (byte_done && ser_state == S_CMD && cmd == CMD_OFF
			&& !ctrl[`REG_OPMODE][`SUPPLY_ON_BIT] && !wake_s && (&key_s)) begin
			off_mode_o <= 1'b1;
		end else if (wake_s || !(&key_s)) begin
			off_mode_o <= 1'b0;
		end
	end

	// line driver: frame data, transparent stream or released
	logic transparent;
	assign transparent = ctrl[`REG_OPMODE][`TRANSPARENT_BIT];
	always_comb begin
		if (!pins.cs) begin
			serial_out_line_o    = transparent ? demod_s : 1'b0;
			serial_out_line_oe_o = transparent;
		end else begin
			serial_out_line_o    = tx_sh[7];
			serial_out_line_oe_o = reset_out_n_i;
		end
	end

	// polling configuration
	poll_cfg_t cfg;
	assign cfg = '{sleep:      ctrl[`REG_SLEEP][`SLEEP_MSB:0],
		stretch:    ctrl[`REG_SLEEP][`STRETCH_BIT],
		lim_min:    ctrl[`REG_LIM_MIN][5:0],
		lim_max:    ctrl[`REG_LIM_MAX][5:0],
		check_bits: ctrl[`REG_CHECK_BITS][1:0]};
	logic [1:0] op_mode;
	assign op_mode = {ctrl[`REG_OPMODE][`OP_HI_BIT], ctrl[`REG_OPMODE][`OP_LO_BIT]};

	// digital clock tick
	localparam int DW = $clog2(DCLK_DIV);
	logic [DW-1:0] div_cnt;
	logic          dtick;
	assign dtick = (div_cnt == DW'(DCLK_DIV - 1));
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= dtick ? '0 : div_cnt + 1'b1;
		end
	end

	// sleep length in digital clock periods
	logic [17:0] sleep_len;
	assign sleep_len = 18'(cfg.sleep) * 18'(`SLEEP_UNIT)
		* (cfg.stretch ? 18'(`STRETCH_FACTOR) : 18'h0_0001);

	poll_state_t poll_state;
	logic [17:0] ptimer;       // phase timer in dclk periods
	logic [4:0]  passes;       // good edge intervals
	logic [4:0]  need;         // intervals required
	logic        demod_edge;
	logic        in_window;
	assign need       = 5'(`EDGES_PER_STEP * cfg.check_bits);
	assign demod_edge = demod_s != demod_d;
	assign in_window  = ptimer >= 18'(cfg.lim_min) && ptimer < 18'(cfg.lim_max);
	assign rx_event   = poll_state == P_CHECK && demod_edge && in_window
		&& passes + 5'h01 >= need;

	// receive sequencer
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			poll_state <= P_IDLE;
			ptimer     <= '0;
			passes     <= '0;
		end else if (!op_mode[1]) begin
			poll_state <= P_IDLE;
		end else begin
			unique case (poll_state)
				P_IDLE: begin
					ptimer     <= '0;
					poll_state <= op_mode[0] ? P_PLL : P_SLEEP;
				end
				P_SLEEP: begin
					if (ptimer >= sleep_len) begin
						poll_state <= P_PLL;
						ptimer     <= '0;
					end else if (dtick) begin
						ptimer <= ptimer + 18'h0_0001;
					end
				end
				P_PLL: begin
					if (lock_s) begin
						poll_state <= P_SETTLE;
						ptimer     <= '0;
					end
				end
				P_SETTLE: begin
					if (ptimer >= 18'(`SETTLE_TICKS)) begin
						poll_state <= P_CHECK;
						ptimer     <= '0;
						passes     <= '0;
					end else if (dtick) begin
						ptimer <= ptimer + 18'h0_0001;
					end
				end
				P_CHECK: begin
					if (need == 5'h00 || rx_event) begin
						poll_state <= P_RECEIVE;
					end else if (demod_edge && in_window) begin
						passes <= passes + 5'h01;
						ptimer <= '0;
					end else if (demod_edge || ptimer >= 18'(cfg.lim_max)) begin
						poll_state <= op_mode[0] ? P_SETTLE : P_SLEEP;
						ptimer     <= '0;
					end else if (dtick) begin
						ptimer <= ptimer + 18'h0_0001;
					end
				end
				P_RECEIVE: begin
					ptimer <= (demod_edge) ? '0 : ptimer + {17'h0_0000, dtick};
				end
				default: begin
					poll_state <= P_IDLE;
				end
			endcase
		end
	end

	// receiver byte assembly, stops at bit 7 of the next byte once a byte is refused by the full buffer
	logic [2:0] rx_bits;
	logic [7:0] rx_acc;
	assign rx_push = (rx_bits == 3'h0) && rx_full && !ser_push;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_bits <= '0;
			rx_acc  <= '0;
			rx_word <= '0;
			rx_full <= 1'b0;
		end else begin
			if (rx_push && fifo_in_ready) begin
				rx_full <= 1'b0;
			end
			if (poll_state == P_RECEIVE && !transparent && demod_edge && in_window
				&& !(rx_full && rx_bits == 3'h7)) begin
				rx_acc  <= {rx_acc[6:0], demod_d};
				rx_bits <= rx_bits + 3'h1;
				if (rx_bits == 3'h7) begin
					rx_word <= {rx_acc[6:0], demod_d};
					rx_full <= 1'b1;
				end
			end
		end
	end

	assign receiver_awake_pin_o = !(poll_state == P_SLEEP || poll_state == P_IDLE);
	assign pll_en_o      = receiver_awake_pin_o;
	assign sig_proc_en_o = poll_state == P_SETTLE || poll_state == P_CHECK
		|| poll_state == P_RECEIVE;
	assign receiving_o   = poll_state == P_RECEIVE;
endmodule

/* File: hdl/xcvr_pkg.sv */
package xcvr_pkg;
	// command types in the top three command bits
	typedef enum logic [2:0] {
		CMD_RD_BUF  = 3'h0,
		CMD_WR_BUF  = 3'h1,
		CMD_RD_REG  = 3'h2,
		CMD_WR_REG  = 3'h3,
		CMD_OFF     = 3'h4,
		CMD_DEL_IRQ = 3'h5
	} cmd_type_t;
	// serial frame phases
	typedef enum logic [5:0] {
		S_CMD    = 6'b00_0001,
		S_RD_BUF = 6'b00_0010,
		S_WR_BUF = 6'b00_0100,
		S_RD_REG = 6'b00_1000,
		S_WR_REG = 6'b01_0000,
		S_IGNORE = 6'b10_0000
	} ser_state_t;
	// receive sequencer phases
	typedef enum logic [5:0] {
		P_IDLE    = 6'b00_0001,
		P_SLEEP   = 6'b00_0010,
		P_PLL     = 6'b00_0100,
		P_SETTLE  = 6'b00_1000,
		P_CHECK   = 6'b01_0000,
		P_RECEIVE = 6'b10_0000
	} poll_state_t;
	// serial pins after synchronisation
	typedef struct packed {
		logic cs;
		logic sck;
		logic sdi;
	} ser_pins_t;
	// polling configuration taken from the control registers
	typedef struct packed {
		logic [4:0] sleep;
		logic       stretch;
		logic [5:0] lim_min;
		logic [5:0] lim_max;
		logic [1:0] check_bits;
	} poll_cfg_t;
endpackage

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	import xcvr_pkg::*;
	logic       sys_clk_i, rst_n_i, reset_out_n_i, power_wake_pin_i, demod_i, pll_lock_i;
	logic [4:0] key_inputs_i;
	logic       cs, sck, sdi, demod_run;
	wire        sdo_w;
	logic       serial_out_line_o, serial_out_line_oe_o, interrupt_pin_o, off_mode_o;
	logic       receiver_awake_pin_o, pll_en_o, sig_proc_en_o, receiving_o;
	logic [7:0] tx [16];
	logic [7:0] rx [16];
	int         fail_count, samples_checked, n, dcnt;
	// released line floats so a stale bit cannot pass
	assign sdo_w = serial_out_line_oe_o ? serial_out_line_o : 1'bz;
	xcvr_ctrl #(.DCLK_DIV(2), .BUF_DEPTH(8)) u_dut (.sys_clk_i, .rst_n_i, .reset_out_n_i,
		.cs_i(cs), .sck_i(sck), .serial_in_line_i(sdi), .serial_out_line_o,
		.serial_out_line_oe_o, .analog_dummy_i(1'b0), .power_wake_pin_i, .supply_low_i(1'b0),
		.aux_power_i(1'b0), .key_inputs_i, .demod_i, .pll_lock_i, .interrupt_pin_o,
		.off_mode_o, .receiver_awake_pin_o, .pll_en_o, .sig_proc_en_o, .receiving_o);
	xcvr_host u_host (.sys_clk_i, .sdo_i(sdo_w), .cs_o(cs), .sck_o(sck), .sdi_o(sdi));
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	// preburst-like demod, 40 clocks per half bit
	always @(negedge sys_clk_i) begin
		if (demod_run) begin
			dcnt <= (dcnt == 39) ? 0 : dcnt + 1;
			if (dcnt == 39) begin
				demod_i <= ~demod_i;
			end
		end
	end
	task automatic test_done();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one frame of n bytes; short frames take bytes as arguments
	task automatic run(input int n, input logic [7:0] b0 = 8'h00, b1 = 8'h00, b2 = 8'h00);
		if (n <= 3) begin
			tx[0] = b0;
			tx[1] = b1;
			tx[2] = b2;
		end
		u_host.open_frame();
		for (int i = 0; i < n; i++) u_host.xfer(tx[i], rx[i]);
		u_host.close_frame();
	endtask
	// bounded wait on awake (0) or receiving (1)
	task automatic wait_for(input bit sel, input logic lvl, input int lim, output int k);
		k = 0;
		while (((sel ? receiving_o : receiver_awake_pin_o) !== lvl) && k < lim) begin
			@(negedge sys_clk_i);
			k++;
		end
		chk("wait", k < lim, 1'b1);
	endtask
	initial begin
		repeat (100000) @(posedge sys_clk_i);
		fail_count++;
		test_done();
	end
	initial begin
		{rst_n_i, power_wake_pin_i, demod_i, pll_lock_i, demod_run, dcnt} = '0;
		reset_out_n_i = 1'b1;
		key_inputs_i = 5'h1F;
		repeat (5) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		chk("oe_idle", serial_out_line_oe_o, 1'b0);
		repeat (10) @(negedge sys_clk_i);
		// clear power-up flags, then registers at reset
		run(2, 8'h48);
		run(2, 8'h48);
		chk("status", rx[1], 8'h00);
		chk("irq_clr", interrupt_pin_o, 1'b0);
		run(3, 8'h45);
		chk("lim_min_rst", rx[1], 8'h0E);
		chk("lim_max_rst", rx[2], 8'h18);
		run(3, 8'h65, 8'h0A, 8'h20);
		chk("wr_echo0", rx[1], 8'h65);
		chk("wr_echo1", rx[2], 8'h0A);
		run(3, 8'h45);
		chk("rd_count", rx[0], 8'h00);
		chk("rd_lim_min", rx[1], 8'h0A);
		chk("rd_lim_max", rx[2], 8'h20);
		// fill the buffer past full, then drain past empty
		for (int i = 0; i < 10; i++) tx[i] = (i == 0) ? 8'h20 : 8'h80 + 8'(i);
		run(10);
		for (int i = 1; i < 10; i++) chk("buf_echo", rx[i], tx[i-1]);
		for (int i = 0; i < 11; i++) tx[i] = 8'h00;
		run(11);
		chk("buf_count", rx[0], 8'h08);
		for (int i = 1; i < 11; i++) chk("buf_data", rx[i], (i < 9) ? 8'h80 + 8'(i) : 8'h00);
		// unused codes with a write attempt behind them
		for (int k = 6; k < 8; k++) begin
			run(2, {3'(k), 5'h00}, 8'h3F);
			chk("unused_reply", rx[1], 8'h00);
		end
		reset_out_n_i = 1'b0;
		run(2, 8'h65, 8'h3F);
		reset_out_n_i = 1'b1;
		run(2, 8'h45);
		chk("buf_empty", rx[0], 8'h00);
		chk("kept_lim", rx[1], 8'h0A);
		// wake event, delete, status, off command
		power_wake_pin_i = 1'b1;
		repeat (10) @(negedge sys_clk_i);
		chk("irq_wake", interrupt_pin_o, 1'b1);
		run(1, 8'h80);
		chk("off_refused", off_mode_o, 1'b0);
		run(1, 8'hA0);
		chk("irq_del", interrupt_pin_o, 1'b0);
		run(2, 8'h48);
		chk("st_wake", rx[1], 8'h20);
		power_wake_pin_i = 1'b0;
		repeat (10) @(negedge sys_clk_i);
		run(1, 8'h80);
		chk("off_set", off_mode_o, 1'b1);
		key_inputs_i = 5'h1E;
		repeat (10) @(negedge sys_clk_i);
		chk("off_key", off_mode_o, 1'b0);
		key_inputs_i = 5'h1F;
		repeat (10) @(negedge sys_clk_i);
		run(2, 8'h48);
		run(2, 8'h48);
		chk("st_clear", rx[1], 8'h00);
		// polling: sleep one unit, six edges, pll held unlocked
		run(2, 8'h64, 8'h01);
		run(2, 8'h67, 8'h01);
		run(2, 8'h61, 8'h02);
		wait_for(0, 1'b1, 3000, n);
		repeat (50) @(negedge sys_clk_i);
		chk("pll_wait", {pll_en_o, sig_proc_en_o}, 2'b10);
		pll_lock_i = 1'b1;
		wait_for(0, 1'b0, 2000, n);
		wait_for(0, 1'b1, 20000, n);
		chk("sleep_x1", n >= 2044 && n <= 2060, 1'b1);
		run(2, 8'h64, 8'h21);
		wait_for(0, 1'b1, 20000, n);
		wait_for(0, 1'b0, 2000, n);
		wait_for(0, 1'b1, 20000, n);
		chk("sleep_x8", n >= 16380 && n <= 16400, 1'b1);
		// continuous, transparent, valid edges present
		run(2, 8'h61, 8'h00);
		run(2, 8'h61, 8'h0B);
		// park first, then time the first edge into mid-window of the check
		repeat (24) @(negedge sys_clk_i);
		demod_run = 1'b1;
		wait_for(1, 1'b1, 4000, n);
		chk("rx_found", receiving_o, 1'b1);
		while (dcnt != 20) @(negedge sys_clk_i);
		chk("tr_oe", serial_out_line_oe_o, 1'b1);
		chk("tr_data", serial_out_line_o, demod_i);
		test_done();
	end
endmodule

/* File: testbench/xcvr_ctrl_chk.sv */
`timescale 1ns/10ps
module xcvr_ctrl_chk (
	input wire logic       sys_clk_i,
	input wire logic       rst_n_i,
	input wire logic       reset_out_n_i,
	input wire logic       power_wake_pin_i,
	input wire logic [4:0] key_inputs_i,
	input wire logic       serial_out_line_oe_o,
	input wire logic       off_mode_o,
	input wire logic       receiver_awake_pin_o,
	input wire logic       pll_en_o,
	input wire logic       sig_proc_en_o,
	input wire logic       receiving_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic       pins_quiet; // no wake, no key pressed
	logic [3:0] quiet_run;  // quiet cycles, saturating
	assign pins_quiet = (&key_inputs_i) & ~power_wake_pin_i;
	// how long the wake and key pins have stayed quiet
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			quiet_run <= 4'h0;
		end else if (!pins_quiet) begin
			quiet_run <= 4'h0;
		end else if (quiet_run != 4'hF) begin
			quiet_run <= quiet_run + 4'h1;
		end
	end
	AST_REL_PIN: assert property (!reset_out_n_i && !$past(reset_out_n_i) |-> !serial_out_line_oe_o)
		else $error("line driven while reset pin low");
	AST_AWAKE_PLL: assert property (receiver_awake_pin_o == pll_en_o)
		else $error("awake pin differs from pll enable");
	AST_PLL_FIRST: assert property ($rose(pll_en_o) |-> !sig_proc_en_o ##1 pll_en_o[*8])
		else $error("start-up did not begin with pll alone");
	AST_SIG_AFTER: assert property ($rose(sig_proc_en_o) |-> $past(pll_en_o))
		else $error("signal path enabled before pll");
	AST_RX_PATH: assert property (receiving_o |-> sig_proc_en_o && pll_en_o)
		else $error("receiving without signal path");
	AST_SETTLE: assert property ($rose(receiving_o) |-> $past(sig_proc_en_o, 16))
		else $error("receiving without settling time");
	AST_SLEEP_DARK: assert property (!receiver_awake_pin_o |-> !sig_proc_en_o && !receiving_o)
		else $error("signal path active in sleep");
	AST_OFF_IN: assert property ($rose(off_mode_o) |-> quiet_run >= 4'h4)
		else $error("off entered with wake or key active");
	AST_OFF_OUT: assert property ($fell(off_mode_o) |-> quiet_run < 4'h8)
		else $error("off left without wake or key");
endmodule

bind xcvr_ctrl xcvr_ctrl_chk u_chk (.sys_clk_i, .rst_n_i, .reset_out_n_i, .power_wake_pin_i,
	.key_inputs_i, .serial_out_line_oe_o, .off_mode_o, .receiver_awake_pin_o, .pll_en_o,
	.sig_proc_en_o, .receiving_o);

/* File: testbench/xcvr_host.sv */
`timescale 1ns/10ps
module xcvr_host (
	input  wire logic sys_clk_i,
	input  wire logic sdo_i,  // device reply line
	output logic      cs_o,   // select, high in a frame
	output logic      sck_o,  // stands low outside frames
	output logic      sdi_o   // command and data bits
);
	// idle until the bench opens a frame
	initial begin
		cs_o = 1'b0;
		sck_o = 1'b0;
		sdi_o = 1'b1;
	end
	// select, then let the count msb settle
	task automatic open_frame();
		@(negedge sys_clk_i);
		cs_o = 1'b1;
		repeat (4) @(negedge sys_clk_i);
	endtask
	// one byte each way, msb first, 64 ns per bit
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sdi_o = tx[i];
			repeat (5) @(negedge sys_clk_i);
			rx[i] = sdo_i;
			sck_o = 1'b1;
			repeat (3) @(negedge sys_clk_i);
			sck_o = 1'b0;
		end
	endtask
	// release select; data line no longer meaningful
	task automatic close_frame();
		repeat (4) @(negedge sys_clk_i);
		cs_o = 1'b0;
		sdi_o = ~sdi_o;
		repeat (6) @(negedge sys_clk_i);
	endtask
endmodule
